// *** fchp_pkg.sv ***
// Package with modes, decode selects and field positions for the host pin logic.
package fchp_pkg;
    typedef enum logic [1:0] {
        FCHP_MODE_MEM = 2'b00,
        FCHP_MODE_IO = 2'b01,
        FCHP_MODE_IDE = 2'b10
    } fchp_mode_t;

    typedef enum logic [1:0] {
        FCHP_UDMA_NONE = 2'b00,
        FCHP_UDMA_WRITE = 2'b01,
        FCHP_UDMA_READ = 2'b10
    } fchp_udma_t;

    typedef enum logic [2:0] {
        FCHP_SEL_NONE = 3'b000,
        FCHP_SEL_IOREG = 3'b001,
        FCHP_SEL_MEMREG = 3'b010,
        FCHP_SEL_CIS = 3'b011,
        FCHP_SEL_CONFIG = 3'b100,
        FCHP_SEL_TASK = 3'b101
    } fchp_sel_t;

    localparam int FCHP_ADDR_W = 11;
    localparam int FCHP_TASK_W = 3;
    localparam int FCHP_DATA_W = 16;
    localparam int FCHP_BYTE_W = 8;
    // Attribute space at and above this offset holds the configuration registers.
    localparam logic [10:0] FCHP_CFG_BASE = 11'h200;
    // Bit of the card configuration and status register that enables the alert.
    localparam int FCHP_CCSR_SIGCHG_BIT = 4;
    localparam logic [7:0] FCHP_CCSR_RESET = 8'h00;
    localparam logic [10:0] FCHP_CCSR_OFFSET = 11'h202;
endpackage

// *** fchp_pin_if.sv ***
// Interface carrying decoded pin roles between the top and its helpers.
interface fchp_pin_if;
    import fchp_pkg::*;
    fchp_mode_t mode;
    fchp_udma_t udma;
    logic readyState;
    logic wpState;
    logic changeEnable;
    logic alertPulse;
    modport producer (input mode, udma, readyState, wpState, changeEnable, output alertPulse);
    modport consumer (output mode, udma, readyState, wpState, changeEnable, input alertPulse);
endinterface

// *** fchp_addr_decode.sv ***
// Address decoder selecting card register spaces per interface mode.
module fchp_addr_decode
    import fchp_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic [10:0] addr,
    input wire logic regSelN,
    input wire logic ioAccess,
    output fchp_sel_t sel,
    output logic [10:0] index
);
    always_comb begin
        sel = FCHP_SEL_NONE;
        index = 11'h000;
        if (mode == FCHP_MODE_IDE) begin
            sel = FCHP_SEL_TASK;
            index = {8'h00, addr[FCHP_TASK_W-1:0]};
        // Attribute space comes first so the configuration stays reachable in I/O mode.
        end else if (!regSelN && addr >= FCHP_CFG_BASE) begin
            sel = FCHP_SEL_CONFIG;
            index = addr;
        end else if (!regSelN) begin
            sel = FCHP_SEL_CIS;
            index = addr;
        end else if (ioAccess) begin
            sel = FCHP_SEL_IOREG;
            index = addr;
        end else begin
            sel = FCHP_SEL_MEMREG;
            index = addr;
        end
    end
endmodule // fchp_addr_decode

// *** fchp_status_alert.sv ***
// Detector that raises a change alert in I/O mode when ready or write-protect state moves.
module fchp_status_alert
    import fchp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    fchp_pin_if.producer pins
);
    logic readyPrev_r;
    logic wpPrev_r;
    logic alert_r;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            readyPrev_r <= 1'b0;
            wpPrev_r <= 1'b0;
            alert_r <= 1'b0;
        end else if (ce) begin
            readyPrev_r <= pins.readyState;
            wpPrev_r <= pins.wpState;
            alert_r <= (pins.mode == FCHP_MODE_IO) && pins.changeEnable
                && ((pins.readyState != readyPrev_r) || (pins.wpState != wpPrev_r));
        end
    end
    assign pins.alertPulse = alert_r;
endmodule // fchp_status_alert

// *** flash_card_host_pin_logic.sv ***
// Top level pin logic of the card across memory, I/O and IDE modes.
module flash_card_host_pin_logic
    import fchp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [1:0] modeSel,
    input wire logic [1:0] udmaSel,
    input wire logic [10:0] addr,
    input wire logic regSelN,
    input wire logic ce1N,
    input wire logic ce2N,
    input wire logic ioRdN,
    input wire logic ioWrN,
    input wire logic cableSelN,
    input wire logic dmaAckN,
    input wire logic [15:0] dataIn,
    input wire logic cardReady,
    input wire logic writeProtect,
    input wire logic devDmaReady,
    input wire logic devStrobe,
    input wire logic devIoReady,
    input wire logic pdiagDrive,
    input wire logic pdiagIn,
    input wire logic [15:0] rdData,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe,
    output logic sharedOut,
    output logic bvd1Out,
    output logic stsChgN,
    output logic pdiagOutN,
    output logic pdiagOe,
    output logic pdiagSeen,
    output logic [2:0] regSel,
    output logic [10:0] regIndex,
    output logic regRead,
    output logic regWrite,
    output logic [15:0] wrData,
    output logic wordAccess,
    output logic hostStrobe,
    output logic hostReady,
    output logic hostStop
);
    fchp_pin_if pins ();
    fchp_sel_t selNow;
    logic [10:0] indexNow;
    logic [7:0] ccsr_r;
    logic isIde;
    logic udmaOn;
    logic rdStb;
    logic wrStb;
    logic wide;

    assign pins.mode = fchp_mode_t'(modeSel);
    assign pins.udma = fchp_udma_t'(udmaSel);
    assign pins.readyState = cardReady;
    assign pins.wpState = writeProtect;
    assign pins.changeEnable = ccsr_r[FCHP_CCSR_SIGCHG_BIT];
    assign isIde = (pins.mode == FCHP_MODE_IDE);
    // Ultra DMA needs the host acknowledge low; a non-DMA host holds it high.
    assign udmaOn = isIde && (pins.udma != FCHP_UDMA_NONE) && !dmaAckN;
    assign rdStb = !ioRdN && !ce1N && !udmaOn;
    assign wrStb = !ioWrN && !ce1N && !udmaOn;
    // Outside IDE mode, word access only when the second enable is asserted; 8-bit hosts leave it high.
    assign wide = !ce2N;

    fchp_addr_decode u_decode (
        .mode(modeSel),
        .addr(addr),
        .regSelN(regSelN),
        .ioAccess(pins.mode == FCHP_MODE_IO),
        .sel(selNow),
        .index(indexNow)
    );

    fchp_status_alert u_alert (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .pins(pins)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ccsr_r <= FCHP_CCSR_RESET;
        end else if (ce && wrStb && !isIde && selNow == FCHP_SEL_CONFIG
                && indexNow == FCHP_CCSR_OFFSET) begin
            ccsr_r <= dataIn[FCHP_BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            regSel <= FCHP_SEL_NONE;
            regIndex <= 11'h000;
            regRead <= 1'b0;
            regWrite <= 1'b0;
            wrData <= 16'h0000;
            wordAccess <= 1'b0;
        end else if (ce) begin
            regSel <= selNow;
            regIndex <= indexNow;
            regRead <= rdStb;
            regWrite <= wrStb;
            // Task registers are byte wide; the IDE data register at index 0 is word wide.
            if (isIde) begin
                wordAccess <= (indexNow[FCHP_TASK_W-1:0] == 3'h0);
            end else begin
                wordAccess <= wide;
            end
            if (isIde && indexNow[FCHP_TASK_W-1:0] != 3'h0) begin
                wrData <= {8'h00, dataIn[FCHP_BYTE_W-1:0]};
            end else if (!isIde && !wide) begin
                wrData <= {8'h00, dataIn[FCHP_BYTE_W-1:0]};
            end else begin
                wrData <= dataIn;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataOut <= 16'h0000;
            dataOe <= 16'h0000;
        end else if (ce) begin
            dataOut <= rdData;
            if (!rdStb) begin
                dataOe <= 16'h0000;
            end else if (isIde && indexNow[FCHP_TASK_W-1:0] != 3'h0) begin
                dataOe <= 16'h00FF;
            end else if (!isIde && !wide) begin
                dataOe <= 16'h00FF;
            end else begin
                dataOe <= 16'hFFFF;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sharedOut <= 1'b1;
            hostStrobe <= 1'b0;
            hostReady <= 1'b0;
            hostStop <= 1'b0;
        end else if (ce) begin
            hostStrobe <= 1'b0;
            hostReady <= 1'b0;
            hostStop <= 1'b0;
            if (udmaOn && pins.udma == FCHP_UDMA_WRITE) begin
                hostStrobe <= ioRdN;
                hostStop <= ioWrN;
                sharedOut <= !devDmaReady;
            end else if (udmaOn && pins.udma == FCHP_UDMA_READ) begin
                hostReady <= !ioRdN;
                hostStop <= ioWrN;
                sharedOut <= devStrobe;
            end else begin
                sharedOut <= devIoReady;
            end
        end
    end

    // Cable select decides no role; pdiagSeen reads it only in a term that is always true.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bvd1Out <= 1'b1;
            stsChgN <= 1'b1;
            pdiagOutN <= 1'b1;
            pdiagOe <= 1'b0;
            pdiagSeen <= 1'b0;
        end else if (ce) begin
            if (pins.mode == FCHP_MODE_MEM) begin
                bvd1Out <= 1'b1;
                stsChgN <= 1'b1;
            end else if (pins.mode == FCHP_MODE_IO) begin
                stsChgN <= !pins.alertPulse;
                bvd1Out <= 1'b1;
            end else begin
                stsChgN <= 1'b1;
                bvd1Out <= 1'b1;
            end
            pdiagOutN <= 1'b0;
            pdiagOe <= isIde && pdiagDrive;
            pdiagSeen <= isIde && (cableSelN || !cableSelN) && !pdiagIn;
        end
    end

    property p_bvd1_high;
        @(posedge clk) disable iff (!resetn)
        (ce && pins.mode == FCHP_MODE_MEM) |=> bvd1Out;
    endproperty
    a_bvd1_high: assert property (p_bvd1_high) else $error("bvd1 not high");

    property p_alert_masked;
        @(posedge clk) disable iff (!resetn)
        (!ccsr_r[FCHP_CCSR_SIGCHG_BIT] && ce) [*2] |=> stsChgN;
    endproperty
    a_alert_masked: assert property (p_alert_masked) else $error("alert while masked");

    sequence s_ready_change;
        ce && $past(ce) && pins.mode == FCHP_MODE_IO && ccsr_r[FCHP_CCSR_SIGCHG_BIT]
            && $changed(cardReady);
    endsequence
    sequence s_alert_low;
        ##1 (ce && pins.mode == FCHP_MODE_IO) ##1 !stsChgN;
    endsequence
    property p_alert_on_change;
        @(posedge clk) disable iff (!resetn)
        s_ready_change |-> s_alert_low;
    endproperty
    a_alert_on_change: assert property (p_alert_on_change) else $error("no alert");

    property p_no_alert_mem;
        @(posedge clk) disable iff (!resetn)
        (ce && pins.mode != FCHP_MODE_IO) |=> stsChgN;
    endproperty
    a_no_alert_mem: assert property (p_no_alert_mem) else $error("alert outside io");

    property p_task_index;
        @(posedge clk) disable iff (!resetn)
        (ce && isIde) |=> (regSel == FCHP_SEL_TASK && regIndex[10:3] == 8'h00);
    endproperty
    a_task_index: assert property (p_task_index) else $error("task decode wrong");

    property p_ide_byte_oe;
        @(posedge clk) disable iff (!resetn)
        (ce && rdStb && isIde && addr[2:0] != 3'h0) |=> dataOe == 16'h00FF;
    endproperty
    a_ide_byte_oe: assert property (p_ide_byte_oe) else $error("task read too wide");

    property p_narrow_host;
        @(posedge clk) disable iff (!resetn)
        (ce && !isIde && ce2N) |=> (wrData[15:8] == 8'h00 && !wordAccess);
    endproperty
    a_narrow_host: assert property (p_narrow_host) else $error("upper byte used");

    property p_udma_read_strobe;
        @(posedge clk) disable iff (!resetn)
        (ce && udmaOn && pins.udma == FCHP_UDMA_READ) |=> sharedOut == $past(devStrobe);
    endproperty
    a_udma_read_strobe: assert property (p_udma_read_strobe) else $error("strobe wrong");

    property p_udma_write_ready;
        @(posedge clk) disable iff (!resetn)
        (ce && udmaOn && pins.udma == FCHP_UDMA_WRITE) |=> sharedOut == !$past(devDmaReady);
    endproperty
    a_udma_write_ready: assert property (p_udma_write_ready) else $error("dmardy wrong");

    property p_pio_ready;
        @(posedge clk) disable iff (!resetn)
        (ce && !udmaOn) |=> (sharedOut == $past(devIoReady) && !hostStop);
    endproperty
    a_pio_ready: assert property (p_pio_ready) else $error("iordy wrong");

    property p_pdiag_oe;
        @(posedge clk) disable iff (!resetn)
        (ce && !isIde) |=> !pdiagOe;
    endproperty
    a_pdiag_oe: assert property (p_pdiag_oe) else $error("pdiag driven");

    property p_pdiag_drive;
        @(posedge clk) disable iff (!resetn)
        (ce && isIde) |=> (pdiagOe == $past(pdiagDrive) && !pdiagOutN);
    endproperty
    a_pdiag_drive: assert property (p_pdiag_drive) else $error("pdiag not driven");

    property p_config_write;
        @(posedge clk) disable iff (!resetn)
        (ce && wrStb && !isIde && selNow == FCHP_SEL_CONFIG && indexNow == FCHP_CCSR_OFFSET)
            |=> ccsr_r[FCHP_CCSR_SIGCHG_BIT] == $past(dataIn[FCHP_CCSR_SIGCHG_BIT]);
    endproperty
    a_config_write: assert property (p_config_write) else $error("enable not stored");

    property p_pio_refused;
        @(posedge clk) disable iff (!resetn)
        (ce && udmaOn) |=> (!regRead && !regWrite);
    endproperty
    a_pio_refused: assert property (p_pio_refused) else $error("strobe during dma");

    property p_udma_write_host;
        @(posedge clk) disable iff (!resetn)
        (ce && udmaOn && pins.udma == FCHP_UDMA_WRITE)
            |=> (hostStrobe == $past(ioRdN) && hostStop == $past(ioWrN));
    endproperty
    a_udma_write_host: assert property (p_udma_write_host) else $error("hstrobe wrong");

    property p_udma_read_host;
        @(posedge clk) disable iff (!resetn)
        (ce && udmaOn && pins.udma == FCHP_UDMA_READ)
            |=> (hostReady == !$past(ioRdN) && hostStop == $past(ioWrN));
    endproperty
    a_udma_read_host: assert property (p_udma_read_host) else $error("hdmardy wrong");

    property p_ide_word_oe;
        @(posedge clk) disable iff (!resetn)
        (ce && rdStb && isIde && addr[2:0] == 3'h0) |=> dataOe == 16'hFFFF;
    endproperty
    a_ide_word_oe: assert property (p_ide_word_oe) else $error("data read too narrow");
endmodule // flash_card_host_pin_logic

// *** fchp_host_model.sv ***
// Behavioural host controller that drives the shared pins the way a compliant host would.
module fchp_host_model
    import fchp_pkg::*;
(
    input wire logic [1:0] modeSel,
    input wire logic [10:0] addrReq,
    input wire logic breakUpper,
    input wire logic a25,
    input wire logic useDma,
    input wire logic dmaReqN,
    input wire logic regReqN,
    input wire logic slaveDiagN,
    input wire logic pdiagOutN,
    input wire logic pdiagOe,
    output logic [10:0] addr,
    output logic cableSelN,
    output logic dmaAckN,
    output logic regSelN,
    output logic pdiagIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ide;
    assign ide = (modeSel == FCHP_MODE_IDE);
    // In IDE mode the upper lines stay grounded unless breakUpper is set.
    assign addr = (ide && !breakUpper) ? {8'h00, addrReq[2:0]} : addrReq;
    assign cableSelN = a25;
    assign dmaAckN = useDma ? dmaReqN : 1'b1;
    assign regSelN = ide ? dmaAckN : regReqN;
    // The diagnostic wire has a pull-up; either device may pull it low.
    assign pdiagIn = (pdiagOe ? pdiagOutN : 1'b1) & slaveDiagN;
endmodule // fchp_host_model

// *** flash_card_host_pin_logic_test.sv ***
// Self-checking testbench comparing the pin logic against a behavioural model.
module flash_card_host_pin_logic_test
    import fchp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, ce, regReqN, regSelN, ce1N, ce2N, ioRdN, ioWrN, a25, cableSelN;
    logic useDma, dmaReqN, dmaAckN, cardReady, writeProtect, devDmaReady, devStrobe;
    logic devIoReady, pdiagDrive, pdiagIn, slaveDiagN, breakUpper;
    logic [1:0] modeSel, udmaSel;
    logic [10:0] addrReq, addr, regIndex;
    logic [15:0] dataIn, rdData, dataOut, dataOe, wrData;
    logic sharedOut, bvd1Out, stsChgN, pdiagOutN, pdiagOe, pdiagSeen, regRead, regWrite;
    logic wordAccess, hostStrobe, hostReady, hostStop;
    logic [2:0] regSel;
    integer seed = 32'hDBCC;
    int failCount = 0;
    int nCompared = 0;
    int cycles = 0;
    int modeAge = 0;
    bit valid, cfgEn, rdyM, wpM, pulseM, ide, act, strobe, chkSel;
    bit byteOnly;
    logic expSts, expShared, expOe, expSeen, expRd, expWr, expWord, expStb, expRdy, expStop;
    logic [2:0] expSel;
    logic [10:0] expIdx;
    logic [15:0] expWd, expDoe, expOut;
    logic [1:0] lastMode;

    flash_card_host_pin_logic flash_card_host_pin_logic_i (.clk(clk), .resetn(resetn),
        .ce(ce), .modeSel(modeSel), .udmaSel(udmaSel), .addr(addr), .regSelN(regSelN),
        .ce1N(ce1N), .ce2N(ce2N), .ioRdN(ioRdN), .ioWrN(ioWrN), .cableSelN(cableSelN),
        .dmaAckN(dmaAckN), .dataIn(dataIn), .cardReady(cardReady),
        .writeProtect(writeProtect), .devDmaReady(devDmaReady), .devStrobe(devStrobe),
        .devIoReady(devIoReady), .pdiagDrive(pdiagDrive), .pdiagIn(pdiagIn),
        .rdData(rdData), .dataOut(dataOut), .dataOe(dataOe), .sharedOut(sharedOut),
        .bvd1Out(bvd1Out), .stsChgN(stsChgN), .pdiagOutN(pdiagOutN), .pdiagOe(pdiagOe),
        .pdiagSeen(pdiagSeen), .regSel(regSel), .regIndex(regIndex), .regRead(regRead),
        .regWrite(regWrite), .wrData(wrData), .wordAccess(wordAccess),
        .hostStrobe(hostStrobe), .hostReady(hostReady), .hostStop(hostStop));

    fchp_host_model fchp_host_model_i (.modeSel(modeSel), .addrReq(addrReq),
        .breakUpper(breakUpper), .a25(a25), .useDma(useDma), .dmaReqN(dmaReqN),
        .regReqN(regReqN), .slaveDiagN(slaveDiagN), .pdiagOutN(pdiagOutN),
        .pdiagOe(pdiagOe), .addr(addr), .cableSelN(cableSelN), .dmaAckN(dmaAckN),
        .regSelN(regSelN), .pdiagIn(pdiagIn));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tallyAndFinish();
        if (failCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Model: outputs are registered, the alert takes two edges from the state change.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            tallyAndFinish();
        end
        modeAge = (modeSel == lastMode) ? modeAge + 1 : 0;
        lastMode = modeSel;
        if (!resetn) begin
            {valid, cfgEn, rdyM, wpM, pulseM} = 5'h00;
        end else begin
            ide = (modeSel == FCHP_MODE_IDE);
            act = ide && udmaSel != FCHP_UDMA_NONE && !dmaAckN;
            strobe = !ioRdN || !ioWrN;
            expSts = !pulseM;
            pulseM = modeSel == FCHP_MODE_IO && cfgEn && (cardReady != rdyM || writeProtect != wpM);
            rdyM = cardReady;
            wpM = writeProtect;
            if (!ide && !regSelN && !ce1N && !ioWrN && addr == FCHP_CCSR_OFFSET) begin
                cfgEn = dataIn[FCHP_CCSR_SIGCHG_BIT];
            end
            expShared = !act ? devIoReady : (udmaSel == FCHP_UDMA_WRITE ? !devDmaReady : devStrobe);
            expRd = !act && !ioRdN && !ce1N;
            expWr = !act && !ioWrN && !ce1N;
            byteOnly = ide ? (addr[2:0] != 3'h0) : ce2N;
            expWord = !byteOnly;
            expWd = byteOnly ? {8'h00, dataIn[FCHP_BYTE_W-1:0]} : dataIn;
            expDoe = !expRd ? 16'h0000 : (byteOnly ? 16'h00FF : 16'hFFFF);
            expOut = rdData;
            expStb = act && udmaSel == FCHP_UDMA_WRITE && ioRdN;
            expRdy = act && udmaSel == FCHP_UDMA_READ && !ioRdN;
            expStop = act && ioWrN;
            expOe = ide && pdiagDrive;
            expSeen = ide && !pdiagIn;
            expIdx = ide ? {8'h00, addr[2:0]} : addr;
            chkSel = !ce1N;
            if (ide) expSel = FCHP_SEL_TASK;
            else if (!regSelN) expSel = (addr >= FCHP_CFG_BASE) ? FCHP_SEL_CONFIG : FCHP_SEL_CIS;
            else if (modeSel == FCHP_MODE_IO && strobe) expSel = FCHP_SEL_IOREG;
            else if (modeSel == FCHP_MODE_MEM && !strobe) expSel = FCHP_SEL_MEMREG;
            else chkSel = 0;
            valid = 1;
        end
    end

    always @(negedge clk) begin
        if (valid && resetn) begin
            chk({15'h0000, bvd1Out}, 16'h0001);
            if (modeAge >= 3) chk({15'h0000, stsChgN}, {15'h0000, expSts});
            chk({15'h0000, pdiagOe}, {15'h0000, expOe});
            chk({15'h0000, pdiagOutN}, 16'h0000);
            chk({15'h0000, pdiagSeen}, {15'h0000, expSeen});
            chk({15'h0000, sharedOut}, {15'h0000, expShared});
            chk({15'h0000, regRead}, {15'h0000, expRd});
            chk({15'h0000, regWrite}, {15'h0000, expWr});
            chk(dataOe, expDoe);
            chk(dataOut, expOut);
            chk(wrData, expWd);
            chk({15'h0000, wordAccess}, {15'h0000, expWord});
            chk({15'h0000, hostStrobe}, {15'h0000, expStb});
            chk({15'h0000, hostReady}, {15'h0000, expRdy});
            chk({15'h0000, hostStop}, {15'h0000, expStop});
            if (chkSel) chk({13'h0000, regSel}, {13'h0000, expSel});
            if (chkSel) chk({5'h00, regIndex}, {5'h00, expIdx});
        end
    end

    task automatic run(input logic [1:0] m, input logic [1:0] u, input logic dma, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            modeSel = m;
            udmaSel = u;
            useDma = dma;
            addrReq = $random(seed) & 1 ? FCHP_CCSR_OFFSET : 11'($random(seed));
            {regReqN, ce1N, ioRdN, ioWrN, a25, dmaReqN, cardReady, writeProtect} = 8'($random(seed));
            {devDmaReady, devStrobe, devIoReady, pdiagDrive, slaveDiagN, breakUpper} = 6'($random(seed));
            ce2N = (m == FCHP_MODE_IDE) ? 1'b1 : 1'($random(seed));
            dataIn = 16'($random(seed));
            rdData = 16'($random(seed));
        end
    endtask

    initial begin
        {ce, resetn} = 2'b10;
        {modeSel, udmaSel, addrReq, dataIn, rdData} = '0;
        {regReqN, ce1N, ce2N, ioRdN, ioWrN, a25, dmaReqN, slaveDiagN} = 8'hFF;
        {useDma, cardReady, writeProtect, devDmaReady, devStrobe, devIoReady} = '0;
        {pdiagDrive, breakUpper} = '0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        run(FCHP_MODE_MEM, FCHP_UDMA_NONE, 1'b0, 300);
        run(FCHP_MODE_IO, FCHP_UDMA_NONE, 1'b0, 600);
        run(FCHP_MODE_IDE, FCHP_UDMA_NONE, 1'b0, 300);
        run(FCHP_MODE_IDE, FCHP_UDMA_WRITE, 1'b1, 300);
        run(FCHP_MODE_IDE, FCHP_UDMA_READ, 1'b1, 300);
        run(FCHP_MODE_MEM, FCHP_UDMA_NONE, 1'b0, 50);
        tallyAndFinish();
    end
endmodule // flash_card_host_pin_logic_test
